// ==== design/gphd_gpio_high.sv ====
// Function select and pin data registers for general purpose pins 15-18.
// Assumes rst is the fundamental reset and all inputs share clk_sys.
//
// Behaviour
// - Control register bits 15:10 always read as zero.
// - Pin 18 select: input, output, hot-plug interrupt, presence change.
// - Pin 17 select: input, output, input again, power limit exceeded.
// - Pin 16 select: input, output, attention ports 1-3, fault ports 1-3.
// - Pin 15 select: input, output, attention 1-2, port 3 power, faults.
// - Select fields load from EEPROM when present; fundamental reset clears.
// - Data register reads return true pin levels regardless of function.
// - Data writes only change pins configured as plain outputs.
// - Presence change asserts when any port's status and enable both set.
// - Power limit output asserts during PERST or slot limit exceeded.
`timescale 1ns/10ps
`default_nettype none
module gphd_gpio_high
    import gphd_pkg::*;
#(
    parameter int NUM_DN_PORTS = 3
) (
    // Clock and fundamental reset
    input  wire logic                    clk_sys,
    input  wire logic                    rst,
    // Configuration access
    input  wire gphd_cfg_req_type        cfgReq,
    output logic                  [31:0] cfgRdata,
    output logic                         cfgAck,
    // EEPROM load
    input  wire logic                    eeLoad,
    input  wire logic              [9:0] eeCtrl,
    input  wire logic              [3:0] eeData,
    // Hot-plug sources
    input  wire logic                    hotplugIrq,
    input  wire logic              [2:0] presenceChangedStatus,
    input  wire logic              [2:0] presenceChangedEnable,
    input  wire logic                    perstAsserted,
    input  wire logic                    powerLimitCondition,
    input  wire logic              [2:0] attentionIndicator,
    input  wire logic                    powerIndicatorPort3,
    output logic                   [2:0] powerFault,
    // Pins 15-18 and levels of pins 0-14
    input  wire logic              [3:0] pinIn,
    output logic                   [3:0] pinOut,
    output logic                   [3:0] pinOe,
    input  wire logic    [LOW_PINS-1:0] lowPinLevel
);

    if (NUM_DN_PORTS != 3) begin : g_bad_ports
        $error("gphd_gpio_high: select codes cover exactly 3 ports");
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [2:0] fieldCode(input logic [9:0] c,
                                             input int i);
        case (i)
            0:       fieldCode = c[2:0];
            1:       fieldCode = c[5:3];
            2:       fieldCode = {1'b0, c[7:6]};
            default: fieldCode = {1'b0, c[9:8]};
        endcase
    endfunction

    function automatic logic isPlainOut(input logic [9:0] c, input int i);
        logic [2:0] f;
        f = fieldCode(c, i);
        isPlainOut = (i < 2) ? (f == SEL3_OUT) : (f[1:0] == SEL2_OUT);
    endfunction

    function automatic logic hitDword(input logic [7:0] a,
                                      input logic [7:0] off);
        hitDword = (a[7:2] == off[7:2]);
    endfunction

    logic [9:0]      ctrl;
    logic [3:0]      dataLatch;
    gphd_hp_src_type src;
    logic [3:0]      decOe;
    logic [3:0]      decDrive;
    logic [2:0]      decFault [NUM_PINS];
    logic [2:0]      next_powerFault;
    logic            ctrlHit;
    logic            dataHit;

    assign ctrlHit = hitDword(cfgReq.addr, CTRL_OFFSET);
    assign dataHit = hitDword(cfgReq.addr, DATA_OFFSET);

    // ----------------------------------------------------------------
    // Hot-plug signal sources
    // ----------------------------------------------------------------
    always_comb begin
        src.hpIrq               = hotplugIrq;
        src.presenceChange      = |(presenceChangedStatus
                                    & presenceChangedEnable);
        src.powerLimitExceeded  = perstAsserted
                                  | powerLimitCondition;
        src.attention           = attentionIndicator;
        src.powerIndicatorPort3 = powerIndicatorPort3;
    end

    // ----------------------------------------------------------------
    // Function select register
    // ----------------------------------------------------------------
    // EEPROM load wins over a same-cycle software write
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl <= CTRL_RESET;
        end else if (eeLoad) begin
            ctrl <= eeCtrl;
        end else if (cfgReq.wr && ctrlHit) begin
            if (cfgReq.be[2]) begin
                ctrl[7:0] <= cfgReq.wdata[CTRL_SHIFT+7:CTRL_SHIFT];
            end
            if (cfgReq.be[3]) begin
                ctrl[9:8] <= cfgReq.wdata[CTRL_SHIFT+9:CTRL_SHIFT+8];
            end
        end
    end

    // ----------------------------------------------------------------
    // Output data latch
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dataLatch <= DATA_RESET;
        end else if (eeLoad) begin
            dataLatch <= eeData;
        end else if (cfgReq.wr && dataHit) begin
            for (int i = 0; i < NUM_PINS; i++) begin
                if (cfgReq.be[(DATA_LSB+i)/8] && isPlainOut(ctrl, i)) begin
                    dataLatch[i] <= cfgReq.wdata[DATA_LSB+i];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Pin function decode
    // ----------------------------------------------------------------
    for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
        gphd_pin_decode #(
            .PIN(p)
        ) u_dec (
            .code     (fieldCode(ctrl, p)),
            .src      (src),
            .dataBit  (dataLatch[p]),
            .oe       (decOe[p]),
            .drive    (decDrive[p]),
            .faultSel (decFault[p])
        );
    end

    // Fault seen on any pin routed to that port; unrouted reads inactive
    always_comb begin
        next_powerFault = 3'b000;
        for (int i = 0; i < NUM_PINS; i++) begin
            next_powerFault = next_powerFault | (decFault[i] & {3{pinIn[i]}});
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pinOut     <= 4'h0;
            pinOe      <= 4'h0;
            powerFault <= 3'b000;
        end else begin
            pinOut     <= decDrive;
            pinOe      <= decOe;
            powerFault <= next_powerFault;
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Low half of the control dword belongs to another register: zero
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cfgRdata <= 32'h0000_0000;
            cfgAck   <= 1'b0;
        end else begin
            cfgAck   <= cfgReq.rd | cfgReq.wr;
            cfgRdata <= 32'h0000_0000;
            if (cfgReq.rd && ctrlHit) begin
                cfgRdata[CTRL_SHIFT+CTRL_WIDTH-1:CTRL_SHIFT] <= ctrl;
            end else if (cfgReq.rd && dataHit) begin
                cfgRdata[DATA_LSB+NUM_PINS-1:DATA_LSB] <= pinIn;
                cfgRdata[LOW_PINS-1:0] <= lowPinLevel;
            end
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_reserved_zero: assert property (
        @(posedge clk_sys) disable iff (rst)
        cfgReq.rd && ctrlHit |=> cfgRdata[31:26] == 6'h00)
        else $error("reserved control bits read nonzero");

    a_pin18_irq: assert property (
        @(posedge clk_sys) disable iff (rst)
        ctrl[9:8] == SEL2_ALT
        |=> pinOe[3] && pinOut[3] == $past(hotplugIrq))
        else $error("pin 18 not carrying hot-plug interrupt");

    a_pin17_input: assert property (
        @(posedge clk_sys) disable iff (rst)
        ctrl[7:6] == SEL2_ALT || ctrl[7:6] == 2'h0_0 |=> !pinOe[2])
        else $error("pin 17 driven while selected as input");

    a_pin16_fault: assert property (
        @(posedge clk_sys) disable iff (rst)
        ctrl[5:3] == SEL3_FLT1 && ctrl[2:0] != SEL3_FLT1
        |=> !pinOe[1] && powerFault[0] == $past(pinIn[1]))
        else $error("pin 16 power fault not routed");

    a_pin15_pwrled: assert property (
        @(posedge clk_sys) disable iff (rst)
        ctrl[2:0] == SEL3_P3
        |=> pinOe[0] && pinOut[0] == $past(powerIndicatorPort3))
        else $error("pin 15 not carrying port 3 power indicator");

    a_fund_reset: assert property (
        @(posedge clk_sys)
        rst |=> ctrl == CTRL_RESET && pinOe == 4'h0)
        else $error("select fields not cleared by reset");

    a_eeprom_load: assert property (
        @(posedge clk_sys) disable iff (rst)
        eeLoad |=> ctrl == $past(eeCtrl))
        else $error("select fields not loaded from EEPROM");

    a_read_level: assert property (
        @(posedge clk_sys) disable iff (rst)
        cfgReq.rd && dataHit
        |=> cfgAck && cfgRdata[18:15] == $past(pinIn))
        else $error("data read does not show pin levels");

    a_write_gated: assert property (
        @(posedge clk_sys) disable iff (rst)
        cfgReq.wr && dataHit && !eeLoad && ctrl[9:8] != SEL2_OUT
        |=> dataLatch[3] == $past(dataLatch[3]))
        else $error("write changed a non-output pin");

    a_presence_chg: assert property (
        @(posedge clk_sys) disable iff (rst)
        ctrl[9:8] == SEL2_HP
        && |(presenceChangedStatus & presenceChangedEnable)
        |=> pinOut[3] && pinOe[3])
        else $error("presence change output not asserted");

    a_power_over: assert property (
        @(posedge clk_sys) disable iff (rst)
        ctrl[7:6] == SEL2_HP && (perstAsserted || powerLimitCondition)
        |=> pinOut[2] && pinOe[2])
        else $error("power limit output not asserted");

endmodule
`default_nettype wire

// ==== design/gphd_pin_decode.sv ====
// One pin's function decoder: select code to drive, enable, fault route.
// Assumes the caller registers the results.
`timescale 1ns/10ps
`default_nettype none
module gphd_pin_decode
    import gphd_pkg::*;
#(
    parameter int PIN = 0
) (
    // Selection
    input  wire logic            [2:0] code,
    input  wire gphd_hp_src_type       src,
    input  wire logic                  dataBit,
    // Result
    output logic                       oe,
    output logic                       drive,
    output logic                 [2:0] faultSel
);

    if (PIN < 0 || PIN >= NUM_PINS) begin : g_bad_pin
        $error("gphd_pin_decode: PIN out of range");
    end

    always_comb begin
        oe       = 1'b0;
        drive    = 1'b0;
        faultSel = 3'b000;
        if (PIN >= 2) begin
            case (code[1:0])
                SEL2_OUT: begin
                    oe    = 1'b1;
                    drive = dataBit;
                end
                SEL2_ALT: begin
                    // Pin 17 treats this code as a plain input
                    if (PIN == 3) begin
                        oe    = 1'b1;
                        drive = src.hpIrq;
                    end
                end
                SEL2_HP: begin
                    oe    = 1'b1;
                    drive = (PIN == 3) ? src.presenceChange
                                       : src.powerLimitExceeded;
                end
                default: begin
                end
            endcase
        end else begin
            case (code)
                SEL3_OUT: begin
                    oe    = 1'b1;
                    drive = dataBit;
                end
                SEL3_ATN1: begin
                    oe    = 1'b1;
                    drive = src.attention[0];
                end
                SEL3_ATN2: begin
                    oe    = 1'b1;
                    drive = src.attention[1];
                end
                SEL3_P3: begin
                    oe    = 1'b1;
                    drive = (PIN == 1) ? src.attention[2]
                                       : src.powerIndicatorPort3;
                end
                SEL3_FLT1: faultSel = 3'b001;
                SEL3_FLT2: faultSel = 3'b010;
                SEL3_FLT3: faultSel = 3'b100;
                default: begin
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// ==== design/gphd_pkg.sv ====
// Constants and carrier types for the high pin function and data block.
// Assumes dword-wide configuration accesses with byte enables.
`default_nettype none
package gphd_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_OFFSET    = 8'h00_C2;
    localparam logic [7:0] DATA_OFFSET    = 8'h00_C4;
    localparam int         CTRL_SHIFT     = 16;
    localparam int         CTRL_WIDTH     = 10;
    localparam int         DATA_LSB       = 15;
    localparam int         NUM_PINS       = 4;
    localparam int         LOW_PINS       = 15;
    localparam logic [9:0] CTRL_RESET     = 10'h000;
    localparam logic [3:0] DATA_RESET     = 4'h0;

    // ----------------------------------------------------------------
    // Select codes
    // ----------------------------------------------------------------
    localparam logic [2:0] SEL3_OUT  = 3'h0_1;
    localparam logic [2:0] SEL3_ATN1 = 3'h0_2;
    localparam logic [2:0] SEL3_ATN2 = 3'h0_3;
    localparam logic [2:0] SEL3_P3   = 3'h0_4;
    localparam logic [2:0] SEL3_FLT1 = 3'h0_5;
    localparam logic [2:0] SEL3_FLT2 = 3'h0_6;
    localparam logic [2:0] SEL3_FLT3 = 3'h0_7;
    localparam logic [1:0] SEL2_OUT  = 2'h0_1;
    localparam logic [1:0] SEL2_ALT  = 2'h0_2;
    localparam logic [1:0] SEL2_HP   = 2'h0_3;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } gphd_cfg_req_type;

    typedef struct packed {
        logic       hpIrq;
        logic       presenceChange;
        logic       powerLimitExceeded;
        logic [2:0] attention;
        logic       powerIndicatorPort3;
    } gphd_hp_src_type;

endpackage
`default_nettype wire

// ==== tb/gphd_gpio_high_test.sv ====
// Self-checking bench for the high pin function and data block.
// Assumes the slot model resolves pin levels from drive and slot side.
`timescale 1ns/10ps
`default_nettype none
module gphd_gpio_high_test
    import gphd_pkg::*;
;
    // ------------------------------------------------------------
    // Signals and reference state
    // ------------------------------------------------------------
    logic                  clk_sys;
    logic                  rst;
    gphd_cfg_req_type      cfgReq;
    logic           [31:0] cfgRdata;
    logic                  cfgAck;
    logic                  eeLoad;
    logic            [9:0] eeCtrl;
    logic            [3:0] eeData;
    logic                  hpIrq;
    logic            [2:0] presSt;
    logic            [2:0] presEn;
    logic                  perstIn;
    logic                  plc;
    logic            [2:0] attn;
    logic                  pwrInd3;
    logic            [2:0] powerFault;
    logic            [3:0] pinIn;
    logic            [3:0] pinOut;
    logic            [3:0] pinOe;
    logic            [3:0] slotLvl;
    logic   [LOW_PINS-1:0] lowLvl;
    logic            [9:0] mCtrl = '0;
    logic            [3:0] mLatch = '0;
    logic            [3:0] eOe;
    logic            [3:0] eDrv;
    logic            [2:0] eFlt;
    logic            [3:0] lvl;
    int                    n_fail = 0;
    int                    n_checks = 0;

    gphd_gpio_high #(.NUM_DN_PORTS(3)) u_dut (
        .clk_sys(clk_sys), .rst(rst), .cfgReq(cfgReq),
        .cfgRdata(cfgRdata), .cfgAck(cfgAck), .eeLoad(eeLoad),
        .eeCtrl(eeCtrl), .eeData(eeData), .hotplugIrq(hpIrq),
        .presenceChangedStatus(presSt), .presenceChangedEnable(presEn),
        .perstAsserted(perstIn), .powerLimitCondition(plc),
        .attentionIndicator(attn), .powerIndicatorPort3(pwrInd3),
        .powerFault(powerFault), .pinIn(pinIn), .pinOut(pinOut),
        .pinOe(pinOe), .lowPinLevel(lowLvl)
    );

    gphd_slot_model u_slot (
        .pinOut(pinOut), .pinOe(pinOe), .slotLevel(slotLvl), .pinIn(pinIn)
    );

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cfg(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, input logic ee,
                       output logic [31:0] rd);
        @(posedge clk_sys);
        cfgReq <= '{rd: !wr, wr: wr, addr: a, be: 4'hF, wdata: wd};
        eeLoad <= ee;
        @(posedge clk_sys);
        cfgReq.rd <= 1'b0;
        cfgReq.wr <= 1'b0;
        eeLoad <= 1'b0;
        #1;
        check(32'(cfgAck), 32'h0000_0001);
        rd = cfgRdata;
    endtask

    function automatic int code(input int i);
        case (i)
            0: return int'(mCtrl[2:0]);
            1: return int'(mCtrl[5:3]);
            2: return int'(mCtrl[7:6]);
            default: return int'(mCtrl[9:8]);
        endcase
    endfunction

    task automatic predict();
        int c;
        eOe = '0;
        eDrv = '0;
        eFlt = '0;
        for (int i = 0; i < 4; i++) begin
            c = code(i);
            if (c == 1) begin
                eOe[i] = 1'b1;
                eDrv[i] = mLatch[i];
            end else if (i < 2 && c >= 5) begin
                eFlt[c - 5] = eFlt[c - 5] | slotLvl[i];
            end else if (i < 2 && c >= 2) begin
                eOe[i] = 1'b1;
                eDrv[i] = (i == 0 && c == 4) ? pwrInd3 : attn[c - 2];
            end else if (i == 2 && c == 3) begin
                eOe[i] = 1'b1;
                eDrv[i] = perstIn | plc;
            end else if (i == 3 && c >= 2) begin
                eOe[i] = 1'b1;
                eDrv[i] = (c == 2) ? hpIrq : |(presSt & presEn);
            end
        end
        lvl = (eOe & eDrv) | (~eOe & slotLvl);
    endtask

    task automatic verify();
        logic [31:0] rd;
        repeat (3) @(posedge clk_sys);
        #1;
        predict();
        check(32'(pinOe), 32'(eOe));
        check(32'(pinOut & eOe), 32'(eDrv));
        check(32'(powerFault), 32'(eFlt));
        cfg(1'b0, 8'hC0, '0, 1'b0, rd);
        check(rd, {6'h00, mCtrl, 16'h0000});
        cfg(1'b0, DATA_OFFSET, '0, 1'b0, rd);
        check(rd, {13'h0000, lvl, lowLvl});
        cfg(1'b0, 8'hC8, '0, 1'b0, rd);
        check(rd, '0);
    endtask

    // Random slot state, then a control write and a data write
    task automatic step(input int k);
        logic [31:0] r;
        logic [31:0] r2;
        logic [31:0] rd;
        logic  [9:0] sel;
        logic        ee;
        r = $urandom;
        r2 = $urandom;
        ee = (k >= 8 && k % 4 == 0);
        sel = (k < 8) ? {k[1:0], k[1:0], k[2:0], k[2:0]} : r[25:16];
        @(posedge clk_sys);
        {hpIrq, presSt, presEn, perstIn, plc, attn, pwrInd3} <= r[12:0];
        slotLvl <= r2[31:28];
        lowLvl <= r2[14:0];
        eeCtrl <= r2[27:18];
        eeData <= r[31:28];
        cfg(1'b1, 8'hC0, {r[31:26], sel, r[15:0]}, ee, rd);
        if (ee) begin
            mCtrl = eeCtrl;
            mLatch = eeData;
        end else begin
            mCtrl = sel;
        end
        cfg(1'b1, DATA_OFFSET, r2, 1'b0, rd);
        for (int i = 0; i < 4; i++) begin
            if (code(i) == 1) mLatch[i] = r2[15 + i];
        end
        verify();
    endtask

    // ------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    initial begin
        #800000;
        n_fail++;
        stop_test();
    end

    initial begin
        rst = 1'b1;
        cfgReq = '0;
        eeLoad = 1'b0;
        {eeCtrl, eeData, slotLvl, lowLvl} = '0;
        {hpIrq, presSt, presEn, perstIn, plc, attn, pwrInd3} = '0;
        void'($urandom(32'h8D15_2F09));
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        verify();
        for (int k = 0; k < 48; k++) step(k);
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        check(32'(pinOe), '0);
        mCtrl = '0;
        mLatch = '0;
        verify();
        stop_test();
    end
endmodule
`default_nettype wire

// ==== tb/gphd_slot_model.sv ====
// Slot-side model: fault lines, buttons and indicators on pins 15-18.
// Assumes the device drive wins wherever its enable is high.
`timescale 1ns/10ps
`default_nettype none
module gphd_slot_model (
    // Device side
    input  wire logic [3:0] pinOut,
    input  wire logic [3:0] pinOe,
    // Slot side
    input  wire logic [3:0] slotLevel,
    output logic      [3:0] pinIn
);
    // Slot always holds its lines, so a released pin never floats
    assign pinIn = (pinOe & pinOut) | (~pinOe & slotLevel);
endmodule
`default_nettype wire
